// ---- verilog/input_event_time_tag_fifo.sv ----
// Captures input pin transitions as time-tagged entries in a FIFO
// feeding a holding register. Pins are synchronous to mclk_i; software
// side releases the holding register with a one-cycle pulse.
`default_nettype none
`include "event_tag_defines.svh"

module input_event_time_tag_fifo
	import event_tag_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int AW    = 2
)(
	input  wire logic                 mclk_i,
	input  wire logic                 arst_n_i,
	input  wire logic                 ce_i,
	input  wire logic [PIN_COUNT-1:0] high_speed_event_input_i,
	input  wire logic                 hold_release_i,
	output entry_type                 hold_data_o,
	output logic                      hold_valid_o,
	output logic                      fifo_empty_o,
	output logic                      overflow_o
);
	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic [3:0]           cap_phase;
		logic [3:0]           tmr_phase;
		logic [TAG_WIDTH-1:0] timer;
		logic [PIN_COUNT-1:0] last_pins;
		hold_state_type       hold_st;
		entry_type            hold;
		logic                 load_pend;
		logic                 overflow;
	} state_type;

	state_type   st_r;
	state_type   st_nxt;
	entry_type   fifo_rd_data;
	logic        fifo_empty;
	logic        fifo_full;
	logic        fifo_wr;
	logic        fifo_rd;
	logic        slot;
	logic [PIN_COUNT-1:0] edges;
	entry_type   new_entry;

	// ********************************
	// Capture slot and entry building
	// ********************************
	// nine-state sampling
	assign slot  = (st_r.cap_phase == `CAPTURE_STATES - 4'h1);
	assign edges = high_speed_event_input_i ^ st_r.last_pins;
	assign new_entry = '{pins: edges, tag: st_r.timer};

	// Holding register takes priority while it and the FIFO are empty
	always_comb
	begin
		fifo_wr = 1'b0;
		fifo_rd = 1'b0;
		if (slot && (edges != '0))
		begin
			if (!(st_r.hold_st == HOLD_EMPTY && fifo_empty && !st_r.load_pend))
				fifo_wr = !fifo_full;
		end
		if (st_r.hold_st == HOLD_EMPTY && !fifo_empty && !st_r.load_pend)
			fifo_rd = 1'b1;
	end

	entry_fifo_mem #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.mclk_i    (mclk_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.wr_i      (fifo_wr),
		.wr_data_i (new_entry),
		.rd_i      (fifo_rd),
		.rd_data_o (fifo_rd_data),
		.empty_o   (fifo_empty),
		.full_o    (fifo_full)
	);

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.load_pend = fifo_rd;
		if (slot)
		begin
			st_nxt.cap_phase = `PHASE_RESET;
			st_nxt.last_pins = high_speed_event_input_i;
		end
		else
			st_nxt.cap_phase = st_r.cap_phase + 4'h1;
		if (st_r.tmr_phase == `TIMER_STATES - 4'h1)
		begin
			st_nxt.tmr_phase = `PHASE_RESET;
			st_nxt.timer     = st_r.timer + TAG_WIDTH'(1);
		end
		else
			st_nxt.tmr_phase = st_r.tmr_phase + 4'h1;
		// Sticky lost-entry flag, cleared only by arst_n_i
		if (slot && (edges != '0) && fifo_full)
			st_nxt.overflow = 1'b1;
		case (st_r.hold_st)
			HOLD_EMPTY:
			begin
				if (slot && (edges != '0) && fifo_empty && !st_r.load_pend)
				begin
					st_nxt.hold    = new_entry;
					st_nxt.hold_st = HOLD_FULL;
				end
				else if (st_r.load_pend)
				begin
					st_nxt.hold    = fifo_rd_data;
					st_nxt.hold_st = HOLD_FULL;
				end
			end
			HOLD_FULL:
			begin
				if (hold_release_i)
					st_nxt.hold_st = HOLD_EMPTY;
			end
			default:
				st_nxt.hold_st = HOLD_EMPTY;
		endcase
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r           <= '0;
			st_r.cap_phase <= `PHASE_RESET;
			st_r.tmr_phase <= `PHASE_RESET;
			st_r.timer     <= `TAG_RESET;
			st_r.hold_st   <= HOLD_EMPTY;
		end
		else if (ce_i)
			st_r <= st_nxt;
	end

	assign hold_data_o  = st_r.hold;
	assign hold_valid_o = (st_r.hold_st == HOLD_FULL);
	assign fifo_empty_o = fifo_empty;
	assign overflow_o   = st_r.overflow;
endmodule : input_event_time_tag_fifo
`default_nettype wire

// ---- pkg/event_tag_defines.svh ----
// Constants for the input event time-tag capture block.
// Assumes inclusion by bare name from design files; the package does not include it.
`ifndef EVENT_TAG_DEFINES_SVH
`define EVENT_TAG_DEFINES_SVH

// Capture resolution in clock states
`define CAPTURE_STATES      4'h9
// Timer advances once per this many states
`define TIMER_STATES        4'h8
`define TAG_RESET           16'h0000
`define PHASE_RESET         4'h0

`endif

// ---- pkg/event_tag_pkg.sv ----
// Types shared by the event time-tag capture block.
// Assumes the defines header is on the include path.
`default_nettype none
package event_tag_pkg;
	localparam int PIN_COUNT = 4;
	localparam int TAG_WIDTH = 16;

	typedef struct packed {
		logic [PIN_COUNT-1:0] pins;
		logic [TAG_WIDTH-1:0] tag;
	} entry_type;

	typedef enum logic [1:0] {
		HOLD_EMPTY = 2'b00,
		HOLD_FULL  = 2'b01
	} hold_state_type;
endpackage : event_tag_pkg
`default_nettype wire

// ---- verilog/entry_fifo_mem.sv ----
// Small FIFO memory for captured entries, registered read data.
// Assumes one clock; caller never writes when full nor reads when empty.
`default_nettype none
module entry_fifo_mem
	import event_tag_pkg::*;
#(
	parameter int DEPTH  = 4,
	parameter int AW     = 2
)(
	input  wire logic      mclk_i,
	input  wire logic      arst_n_i,
	input  wire logic      ce_i,
	input  wire logic      wr_i,
	input  wire entry_type wr_data_i,
	input  wire logic      rd_i,
	output entry_type      rd_data_o,
	output logic           empty_o,
	output logic           full_o
);
	entry_type        mem [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	entry_type        rd_data_r;

	assign rd_data_o = rd_data_r;
	assign empty_o   = (cnt_r == '0);
	assign full_o    = (cnt_r == (AW+1)'(DEPTH));

	// Data array has no reset; contents are qualified by count
	always_ff @(posedge mclk_i)
	begin
		if (ce_i && wr_i)
			mem[wp_r] <= wr_data_i;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			rd_data_r <= '0;
		end
		else if (ce_i)
		begin
			if (wr_i)
				wp_r <= wp_r + AW'(1);
			if (rd_i)
			begin
				rd_data_r <= mem[rp_r];
				rp_r      <= rp_r + AW'(1);
			end
			cnt_r <= cnt_r + (AW+1)'(wr_i) - (AW+1)'(rd_i);
		end
	end
endmodule : entry_fifo_mem
`default_nettype wire

// ---- tb/event_pins_model.sv ----
// Model of the event pins in front of the capture block.
// Assumes the bench asks for pin flips by one-cycle masks.
`default_nettype none
module event_pins_model import event_tag_pkg::*; (
	input  wire logic                 mclk_i,
	input  wire logic [PIN_COUNT-1:0] flip_i,
	output logic      [PIN_COUNT-1:0] pins_o
);
	timeunit 1ns; timeprecision 1ps;
	initial pins_o = 4'h0;
	always @(posedge mclk_i) pins_o <= pins_o ^ flip_i;
endmodule : event_pins_model
`default_nettype wire

// ---- tb/input_event_time_tag_fifo_properties.sv ----
// Port checker for the event capture block.
// Assumes ce_i stays high.
`default_nettype none
module event_tag_checker import event_tag_pkg::*; (
	input wire logic mclk_i, arst_n_i, ce_i, hold_release_i, hold_valid_o, fifo_empty_o, overflow_o,
	input wire logic [PIN_COUNT-1:0] high_speed_event_input_i,
	input wire entry_type hold_data_o
);
	timeunit 1ns; timeprecision 1ps;
	logic [4:0] quiet_r;
	logic [TAG_WIDTH-1:0] last_r;
	logic seen_r;
	// Cycles since a pin moved, saturating
	always_ff @(posedge mclk_i or negedge arst_n_i)
		if (!arst_n_i) {quiet_r, last_r, seen_r} <= '0;
		else
		begin
			quiet_r <= $changed(high_speed_event_input_i) ? 5'h0 : quiet_r + 5'(quiet_r != 5'h1f);
			if ($rose(hold_valid_o)) {last_r, seen_r} <= {hold_data_o.tag, 1'b1};
		end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// Two idle cycles rule out a load from the FIFO, whose empty flag rises a cycle early
	AST_FIRST_HOLD: assert property ((!hold_valid_o && fifo_empty_o)[*2] ##1 hold_valid_o |-> fifo_empty_o)
		else $error("first entry reached fifo");
	AST_QUIET: assert property ((!hold_valid_o && fifo_empty_o)[*2] ##1 hold_valid_o |-> quiet_r < 5'hc)
		else $error("entry without pin change");
	// Hold may be loading from the FIFO while the next entry is written
	AST_FILL: assert property ($fell(fifo_empty_o) |-> $past(hold_valid_o) || hold_valid_o)
		else $error("fifo filled with hold empty");
	AST_STANDS: assert property (hold_valid_o && !hold_release_i |=> hold_valid_o && $stable(hold_data_o))
		else $error("hold changed unreleased");
	AST_ADVANCE: assert property (hold_valid_o && hold_release_i && !fifo_empty_o |=> !hold_valid_o ##2 hold_valid_o)
		else $error("fifo did not advance");
	AST_DROP: assert property (hold_valid_o && hold_release_i && fifo_empty_o |=> !hold_valid_o)
		else $error("release ignored");
	AST_PINS: assert property ($rose(hold_valid_o) |-> hold_data_o.pins != 4'h0)
		else $error("entry with no event");
	AST_ORDER: assert property ($rose(hold_valid_o) && seen_r |-> hold_data_o.tag > last_r)
		else $error("tag not increasing");
	COV_OVF: cover property ($rose(overflow_o));
	COV_MERGE: cover property ($rose(hold_valid_o) && hold_data_o.pins == 4'h6);
	COV_ADV: cover property (hold_valid_o && hold_release_i && !fifo_empty_o);
endmodule : event_tag_checker
bind input_event_time_tag_fifo event_tag_checker event_tag_checker_i (.mclk_i, .arst_n_i, .ce_i,
	.hold_release_i, .hold_valid_o, .fifo_empty_o, .overflow_o, .high_speed_event_input_i, .hold_data_o);
`default_nettype wire

// ---- tb/input_event_time_tag_fifo_test.sv ----
// Scenario bench for the event capture block.
// Assumes registered outputs; values read at an edge are pre-edge.
`default_nettype none
module input_event_time_tag_fifo_test import event_tag_pkg::*;;
	timeunit 1ns; timeprecision 1ps;
	logic mclk_i = 1'b0, arst_n_i = 1'b0, rel_r = 1'b0, valid, empty, ovf;
	logic [PIN_COUNT-1:0] flip_r = 4'h0, pins;
	logic [TAG_WIDTH-1:0] prev;
	entry_type hold;
	int mismatches = 0, cmp_count = 0, cyc = 0, twos = 0;
	always #4 mclk_i = ~mclk_i;
	event_pins_model event_pins_model_i (.mclk_i, .flip_i(flip_r), .pins_o(pins));
	input_event_time_tag_fifo input_event_time_tag_fifo_i (.mclk_i, .arst_n_i, .ce_i(1'b1),
		.high_speed_event_input_i(pins), .hold_release_i(rel_r), .hold_data_o(hold),
		.hold_valid_o(valid), .fifo_empty_o(empty), .overflow_o(ovf));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task complete_run;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task tick(input int n); repeat (n) @(posedge mclk_i); endtask : tick
	task flip(input logic [3:0] m); flip_r <= m; tick(1); flip_r <= 4'h0; endtask : flip
	task wait_valid;
		for (int n = 0; n < 40 && valid !== 1'b1; n++) tick(1);
		chk(valid, 1);
	endtask : wait_valid
	task release_hold;
		prev = hold.tag;
		rel_r <= 1'b1;
		tick(1);
		rel_r <= 1'b0;
		tick(1);
	endtask : release_hold
	task next_entry;
		wait_valid;
		chk((hold.tag - prev) inside {16'h1, 16'h2}, 1);
		twos += int'(hold.tag - prev == 16'h2);
		release_hold;
	endtask : next_entry
	// Toggle inside one slot stays unseen
	task t_first;
		flip(4'h1);
		wait_valid;
		chk(empty, 1);
		chk(hold.pins, 4'h1);
		release_hold;
		flip(4'h2);
		tick(1);
		flip(4'h2);
		tick(20);
		chk(valid, 0);
	endtask : t_first
	task t_merge;
		flip(4'h1);
		wait_valid;
		flip(4'h6);
		tick(12);
		chk(empty, 0);
		release_hold;
		wait_valid;
		chk(hold.pins, 4'h6);
		chk(empty, 1);
	endtask : t_merge
	// One event per slot, ten slots running
	task t_stream;
		release_hold;
		fork
			repeat (10) begin flip(4'h8); tick(8); end
			begin wait_valid; release_hold; repeat (9) next_entry; end
		join
		chk(twos > 0, 1);
	endtask : t_stream
	task t_overflow;
		repeat (6) begin flip(4'h4); tick(8); end
		tick(3);
		chk(ovf, 1);
		release_hold;
		repeat (4) next_entry;
		chk(empty, 1);
		chk(valid, 0);
	endtask : t_overflow
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			complete_run;
		end
	end
	initial
	begin
		tick(4);
		arst_n_i <= 1'b1;
		t_first;
		t_merge;
		t_stream;
		t_overflow;
		complete_run;
	end
endmodule : input_event_time_tag_fifo_test
`default_nettype wire
